// ==== cpu_irq_model.sv ====
/*
 * partner: the embedded cpu interrupt input, sampling the irq line.
 * assumes the line is driven on clk_sys.
 */
`timescale 1ns/1ps
module cpu_irq_model (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic cpu_irq_input_a_n,
    output logic      irq_taken_q
);
    // cpu takes a request while the line is low
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            irq_taken_q <= 1'b0;
        end else begin
            irq_taken_q <= ~cpu_irq_input_a_n;
        end
    end
endmodule : cpu_irq_model

// ==== sync_evt_if.sv ====
/*
 * carrier between the register logic and the sync event latch.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface sync_evt_if;
    logic [3:0] evt;
    logic [3:0] mask;
    logic       rd_clr;
    logic [3:0] src;

    modport latch (input evt, input mask, input rd_clr, output src);
    modport ctrl  (output evt, output mask, output rd_clr, input src);
endinterface : sync_evt_if

// ==== sync_evt_latch.sv ====
/*
 * sticky sync event bits, set only when enabled, cleared by a read.
 * assumes events and the read strobe are on clk_sys.
 */
`timescale 1ns/1ps
module sync_evt_latch (
    input  wire logic   clk_sys,
    input  wire logic   rstn,
    sync_evt_if.latch   sif
);
    logic [3:0] src_q;

    genvar i;
    generate
        for (i = 0; i < sync_irq_pkg::SYNC_BITS; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (!rstn) begin
                    src_q[i] <= sync_irq_pkg::RST_SYNC_SRC[i];
                end else begin
                    // set beats clear; masked events never land
                    src_q[i] <= (src_q[i] & ~sif.rd_clr) | (sif.evt[i] & sif.mask[i]);
                end
            end
        end
    endgenerate

    assign sif.src = src_q;

    a_masked_no_set: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!sif.mask[0] && !src_q[0]) |=> !src_q[0])
        else $error("masked marker event was latched");

    a_clear_on_read: assert property (@(posedge clk_sys) disable iff (!rstn)
        (sif.rd_clr && !(|(sif.evt & sif.mask))) |=> (src_q == 4'h0))
        else $error("source not cleared by read");

    a_set_wins_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        (sif.rd_clr && sif.evt[3] && sif.mask[3]) |=> src_q[3])
        else $error("event lost on clearing read");
endmodule : sync_evt_latch

// ==== sync_irq_ctrl.sv ====
/*
 * sync-channel event register, its mask, main interrupt source 0 with its
 * mask, external pin change latches and the active-low interrupt line.
 * assumes detectors run on clk_sys; ext pins are asynchronous.
 */
// Added by the designer: the address-and-strobe port.
// Summary of operation
// - sync events latch only while enabled
// - reading sync source returns it then clears
// - unused upper bits read as zero
// - bit 3 records missing expected pattern
// - bit 2 records D-channel alignment pattern
// - bit 1 records role-matched frame alignment
// - bit 0 records role-matched channel marker
// - sync mask enables bits 3..0, resets zero
// - any main source bit drives irq low
// - main source bits are condition and mask
// - main bit 5 ORs jitter, noise, zeros
// - jitter condition from external threshold detector
// - noise control bits 6 and 4 used
// - bit 5 zero when inactive or masked
// - pin b change sets bit 4, read clears
// - pin a change sets bit 3, read clears
// - bit 2 follows tx empty, masked
// - bits 1,0 follow rx error, rx full
`timescale 1ns/1ps
module sync_irq_ctrl (
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    input  wire logic        pattern_miss,
    input  wire logic        dchan_align_pattern,
    input  wire logic        portable_part_role,
    input  wire logic        fixed_frame_align_pattern,
    input  wire logic        portable_frame_align_pattern,
    input  wire logic        fixed_marker_pattern,
    input  wire logic        portable_marker_pattern,
    input  wire logic        jitter_over_threshold,
    input  wire logic [7:0]  noise_control,
    input  wire logic [2:0]  dchan_status,
    input  wire logic        ext_irq_pin_a,
    input  wire logic        ext_irq_pin_b,
    output logic             cpu_irq_input_a_n,
    output logic             sync_summary
);
    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
        addr_hit = (a == off);
    endfunction : addr_hit

    sync_evt_if sif ();

    logic [3:0] sync_mask_q;
    logic [5:0] main_mask_q;
    logic [5:0] main_src_q;
    logic [5:0] main_src_d;
    logic [7:0] rdata_q;
    logic       irq_n_q;
    logic       summary_q;
    logic [2:0] pin_a_sync_q;
    logic [2:0] pin_b_sync_q;
    logic       pin_a_level_q;
    logic       pin_b_level_q;
    logic       pin_a_pend_q;
    logic       pin_b_pend_q;
    logic       pin_a_change;
    logic       pin_b_change;
    logic       noise_cond;
    logic       rd_sync_src;
    logic       rd_pin_a;
    logic       rd_pin_b;
    logic       frame_hit;
    logic       marker_hit;

    // role picks which pattern variant counts
    assign frame_hit  = portable_part_role ? portable_frame_align_pattern : fixed_frame_align_pattern;
    assign marker_hit = portable_part_role ? portable_marker_pattern : fixed_marker_pattern;

    assign sif.evt[sync_irq_pkg::SYNC_BIT_MISS]   = pattern_miss;
    assign sif.evt[sync_irq_pkg::SYNC_BIT_DALIGN] = dchan_align_pattern;
    assign sif.evt[sync_irq_pkg::SYNC_BIT_FRAME]  = frame_hit;
    assign sif.evt[sync_irq_pkg::SYNC_BIT_MARKER] = marker_hit;
    assign sif.mask   = sync_mask_q;
    assign sif.rd_clr = rd_sync_src;

    sync_evt_latch u_latch (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .sif     (sif)
    );

    assign rd_sync_src = reg_rd && addr_hit(reg_addr, sync_irq_pkg::OFF_SYNC_SRC);
    assign rd_pin_a    = reg_rd && addr_hit(reg_addr, sync_irq_pkg::OFF_PIN_A_STAT);
    assign rd_pin_b    = reg_rd && addr_hit(reg_addr, sync_irq_pkg::OFF_PIN_B_STAT);

    // mask registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sync_mask_q <= sync_irq_pkg::RST_SYNC_MASK;
        end else if (reg_wr && addr_hit(reg_addr, sync_irq_pkg::OFF_SYNC_MASK)) begin
            sync_mask_q <= reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            main_mask_q <= sync_irq_pkg::RST_MAIN_MASK;
        end else if (reg_wr && addr_hit(reg_addr, sync_irq_pkg::OFF_MAIN_MASK0)) begin
            main_mask_q <= reg_wdata[5:0];
        end
    end

    // external pins: three stages, change counted once stages two and three agree
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pin_a_sync_q <= 3'h0;
            pin_b_sync_q <= 3'h0;
        end else begin
            pin_a_sync_q <= {pin_a_sync_q[1:0], ext_irq_pin_a};
            pin_b_sync_q <= {pin_b_sync_q[1:0], ext_irq_pin_b};
        end
    end

    assign pin_a_change = (pin_a_sync_q[1] == pin_a_sync_q[2]) && (pin_a_sync_q[2] != pin_a_level_q);
    assign pin_b_change = (pin_b_sync_q[1] == pin_b_sync_q[2]) && (pin_b_sync_q[2] != pin_b_level_q);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pin_a_level_q <= 1'b0;
            pin_b_level_q <= 1'b0;
        end else begin
            if (pin_a_sync_q[1] == pin_a_sync_q[2]) begin
                pin_a_level_q <= pin_a_sync_q[2];
            end
            if (pin_b_sync_q[1] == pin_b_sync_q[2]) begin
                pin_b_level_q <= pin_b_sync_q[2];
            end
        end
    end

    // pending change flags, new change beats a status read
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pin_a_pend_q <= 1'b0;
            pin_b_pend_q <= 1'b0;
        end else begin
            pin_a_pend_q <= (pin_a_pend_q & ~rd_pin_a) | pin_a_change;
            pin_b_pend_q <= (pin_b_pend_q & ~rd_pin_b) | pin_b_change;
        end
    end

    // noise summary
    assign noise_cond = jitter_over_threshold
                      | noise_control[sync_irq_pkg::NOISE_CTRL_NOISE_BIT]
                      | noise_control[sync_irq_pkg::NOISE_CTRL_ZERO_BIT];

    // main source: live conditions gated by mask
    always_comb begin
        main_src_d = 6'h00;
        main_src_d[sync_irq_pkg::MAIN_BIT_NOISE]  = noise_cond;
        main_src_d[sync_irq_pkg::MAIN_BIT_PIN_B]  = pin_b_pend_q;
        main_src_d[sync_irq_pkg::MAIN_BIT_PIN_A]  = pin_a_pend_q;
        main_src_d[sync_irq_pkg::MAIN_BIT_TX_EMP] = dchan_status[2];
        main_src_d[sync_irq_pkg::MAIN_BIT_RX_ERR] = dchan_status[1];
        main_src_d[sync_irq_pkg::MAIN_BIT_RX_FUL] = dchan_status[0];
        main_src_d = main_src_d & main_mask_q;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            main_src_q <= sync_irq_pkg::RST_MAIN_SRC;
            irq_n_q    <= 1'b1;
        end else begin
            main_src_q <= main_src_d;
            irq_n_q    <= ~(|main_src_d);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            summary_q <= 1'b0;
        end else begin
            summary_q <= |sif.src;
        end
    end

    // read port, data valid the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_q <= sync_irq_pkg::RST_RDATA;
        end else if (reg_rd) begin
            case (reg_addr)
                sync_irq_pkg::OFF_MAIN_SRC0:  rdata_q <= {2'h0, main_src_q};
                sync_irq_pkg::OFF_SYNC_SRC:   rdata_q <= {4'h0, sif.src};
                sync_irq_pkg::OFF_SYNC_MASK:  rdata_q <= {4'h0, sync_mask_q};
                sync_irq_pkg::OFF_MAIN_MASK0: rdata_q <= {2'h0, main_mask_q};
                sync_irq_pkg::OFF_PIN_A_STAT: rdata_q <= {6'h00, pin_a_pend_q, pin_a_level_q};
                sync_irq_pkg::OFF_PIN_B_STAT: rdata_q <= {6'h00, pin_b_pend_q, pin_b_level_q};
                default:                      rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata         = rdata_q;
    assign cpu_irq_input_a_n = irq_n_q;
    assign sync_summary      = summary_q;

    // checks
    sequence s_src_read;
        reg_rd && addr_hit(reg_addr, sync_irq_pkg::OFF_SYNC_SRC);
    endsequence

    sequence s_pin_a_read;
        rd_pin_a && !pin_a_change;
    endsequence

    a_read_returns_src: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_src_read |=> (reg_rdata == {4'h0, $past(sif.src)}))
        else $error("sync source read data wrong");

    a_upper_bits_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        (reg_rd && (addr_hit(reg_addr, sync_irq_pkg::OFF_MAIN_SRC0)
                 || addr_hit(reg_addr, sync_irq_pkg::OFF_SYNC_SRC))) |=> (reg_rdata[7:6] == 2'h0))
        else $error("reserved bits not zero");

    a_irq_tracks_src: assert property (@(posedge clk_sys) disable iff (!rstn)
        cpu_irq_input_a_n == !(|main_src_q))
        else $error("irq line disagrees with source");

    a_masked_main_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        !main_mask_q[5] |=> !main_src_q[5])
        else $error("noise bit set while masked");

    a_noise_or: assert property (@(posedge clk_sys) disable iff (!rstn)
        (main_mask_q[5] && $stable(main_mask_q) && jitter_over_threshold) |=> main_src_q[5])
        else $error("jitter not reflected in noise bit");

    a_tx_empty_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
        (main_mask_q[2] && dchan_status[2]) |=> main_src_q[2])
        else $error("tx empty not reflected");

    a_pin_read_clear: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_pin_a_read |=> !pin_a_pend_q)
        else $error("pin a flag not cleared by read");

    a_summary_or: assert property (@(posedge clk_sys) disable iff (!rstn)
        ##1 sync_summary == $past(|sif.src))
        else $error("summary differs from sync source");
endmodule : sync_irq_ctrl

// ==== sync_irq_pkg.sv ====
/*
 * constants for the sync-channel event latch and main interrupt source 0:
 * register offsets, field positions, widths and reset values.
 * assumes a 16-bit register address and 8-bit register data.
 */
package sync_irq_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    localparam logic [15:0] OFF_MAIN_SRC0   = 16'hffe0;
    localparam logic [15:0] OFF_SYNC_SRC    = 16'hffe5;
    localparam logic [15:0] OFF_SYNC_MASK   = 16'hffe6;
    localparam logic [15:0] OFF_MAIN_MASK0  = 16'hffe8;
    localparam logic [15:0] OFF_PIN_A_STAT  = 16'hffe9;
    localparam logic [15:0] OFF_PIN_B_STAT  = 16'hffea;

    localparam int SYNC_BITS = 4;
    localparam int MAIN_BITS = 6;

    localparam int SYNC_BIT_MISS   = 3;
    localparam int SYNC_BIT_DALIGN = 2;
    localparam int SYNC_BIT_FRAME  = 1;
    localparam int SYNC_BIT_MARKER = 0;

    localparam int MAIN_BIT_NOISE  = 5;
    localparam int MAIN_BIT_PIN_B  = 4;
    localparam int MAIN_BIT_PIN_A  = 3;
    localparam int MAIN_BIT_TX_EMP = 2;
    localparam int MAIN_BIT_RX_ERR = 1;
    localparam int MAIN_BIT_RX_FUL = 0;

    localparam int NOISE_CTRL_NOISE_BIT = 6;
    localparam int NOISE_CTRL_ZERO_BIT  = 4;

    localparam logic [3:0] RST_SYNC_SRC  = 4'h0;
    localparam logic [3:0] RST_SYNC_MASK = 4'h0;
    localparam logic [5:0] RST_MAIN_SRC  = 6'h00;
    localparam logic [5:0] RST_MAIN_MASK = 6'h00;
    localparam logic [7:0] RST_RDATA     = 8'h00;
endpackage : sync_irq_pkg

// ==== testbench.sv ====
/*
 * self-checking bench for sync_irq_ctrl with a cpu irq partner.
 * assumes a 250 MHz clk_sys and synchronous active-low rstn.
 */
`timescale 1ns/1ps
module testbench;
    logic        clk_sys, rstn, reg_wr, reg_rd, pattern_miss, dchan_align_pattern, portable_part_role;
    logic        fixed_frame_align_pattern, portable_frame_align_pattern, fixed_marker_pattern;
    logic        portable_marker_pattern, jitter_over_threshold, ext_irq_pin_a, ext_irq_pin_b;
    logic        cpu_irq_input_a_n, sync_summary, irq_taken_q, ta, tb;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, noise_control, m, e;
    logic [2:0]  dchan_status;
    int          err_count, num_checks;

    sync_irq_ctrl i_dut (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .pattern_miss, .dchan_align_pattern, .portable_part_role, .fixed_frame_align_pattern,
        .portable_frame_align_pattern, .fixed_marker_pattern, .portable_marker_pattern,
        .jitter_over_threshold, .noise_control, .dchan_status, .ext_irq_pin_a, .ext_irq_pin_b,
        .cpu_irq_input_a_n, .sync_summary);
    cpu_irq_model i_cpu (.clk_sys, .rstn, .cpu_irq_input_a_n, .irq_taken_q);

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [15:0] a, input logic [7:0] x);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, x);
    endtask : rdc

    // one-cycle pattern pulses; w drives the variant of the other role
    task automatic ev(input logic [3:0] v, input logic r, input logic [1:0] w);
        @(posedge clk_sys);
        pattern_miss <= v[3];
        dchan_align_pattern <= v[2];
        portable_part_role <= r;
        portable_frame_align_pattern <= r ? v[1] : w[1];
        fixed_frame_align_pattern <= r ? w[1] : v[1];
        portable_marker_pattern <= r ? v[0] : w[0];
        fixed_marker_pattern <= r ? w[0] : v[0];
        @(posedge clk_sys);
        {pattern_miss, dchan_align_pattern, portable_frame_align_pattern} <= 3'h0;
        {fixed_frame_align_pattern, portable_marker_pattern, fixed_marker_pattern} <= 3'h0;
    endtask : ev

    function automatic logic [7:0] main_exp(input logic [7:0] mk);
        logic n;
        n = jitter_over_threshold | noise_control[6] | noise_control[4];
        return {2'h0, n, tb, ta, dchan_status} & {2'h0, mk[5:0]};
    endfunction : main_exp

    initial begin
        #20000;
        err_count++;
        test_done();
    end

    initial begin
        {rstn, reg_wr, reg_rd, pattern_miss, dchan_align_pattern, portable_part_role} = 6'h0;
        {fixed_frame_align_pattern, portable_frame_align_pattern, fixed_marker_pattern} = 3'h0;
        {portable_marker_pattern, jitter_over_threshold, ext_irq_pin_a, ext_irq_pin_b} = 4'h0;
        {reg_addr, reg_wdata, noise_control, dchan_status, ta, tb} = 37'h0;
        err_count = 0;
        num_checks = 0;
        void'($urandom(58));
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        rdc(sync_irq_pkg::OFF_SYNC_MASK, 8'h00);
        rdc(sync_irq_pkg::OFF_SYNC_SRC, 8'h00);
        wr(sync_irq_pkg::OFF_MAIN_SRC0, 8'hff);
        rdc(sync_irq_pkg::OFF_MAIN_SRC0, 8'h00);
        rdc(16'hffe3, 8'h00);
        chk(8'(cpu_irq_input_a_n), 8'h01);
        ev(4'hf, 1'b0, 2'h3);
        rdc(sync_irq_pkg::OFF_SYNC_SRC, 8'h00);
        repeat (20) begin
            m = 8'($urandom);
            e = 8'($urandom);
            wr(sync_irq_pkg::OFF_SYNC_MASK, m);
            rdc(sync_irq_pkg::OFF_SYNC_MASK, {4'h0, m[3:0]});
            ev(e[3:0], e[7], e[5:4]);
            @(posedge clk_sys);
            #1 chk(8'(sync_summary), 8'(|(e[3:0] & m[3:0])));
            rdc(sync_irq_pkg::OFF_SYNC_SRC, {4'h0, e[3:0] & m[3:0]});
            rdc(sync_irq_pkg::OFF_SYNC_SRC, 8'h00);
        end
        wr(sync_irq_pkg::OFF_SYNC_MASK, 8'h0f);
        fork
            ev(4'h1, 1'b1, 2'h0);
            rdc(sync_irq_pkg::OFF_SYNC_SRC, 8'h00);
        join
        rdc(sync_irq_pkg::OFF_SYNC_SRC, 8'h01);
        repeat (20) begin
            m = 8'($urandom);
            e = 8'($urandom);
            wr(sync_irq_pkg::OFF_MAIN_MASK0, m);
            rdc(sync_irq_pkg::OFF_MAIN_MASK0, {2'h0, m[5:0]});
            ta = e[6];
            tb = e[7];
            @(posedge clk_sys);
            jitter_over_threshold <= e[5];
            noise_control <= 8'($urandom) & {1'b1, e[4], 1'b1, e[3], 4'hf};
            dchan_status <= e[2:0];
            ext_irq_pin_a <= ext_irq_pin_a ^ ta;
            ext_irq_pin_b <= ext_irq_pin_b ^ tb;
            repeat (8) @(posedge clk_sys);
            #1 e = main_exp(m);
            rdc(sync_irq_pkg::OFF_MAIN_SRC0, e);
            chk(8'(cpu_irq_input_a_n), 8'(~|e));
            chk(8'(irq_taken_q), 8'(|e));
            rdc(sync_irq_pkg::OFF_PIN_A_STAT, {6'h0, ta, ext_irq_pin_a});
            rdc(sync_irq_pkg::OFF_PIN_B_STAT, {6'h0, tb, ext_irq_pin_b});
        end
        test_done();
    end
endmodule : testbench
